// ==== verilog/selftest_pkg.sv ====
package selftest_pkg;

    // Test steps, in run order
    localparam logic [2:0] STEP_CRC16_SWBOOT = 3'h0;
    localparam logic [2:0] STEP_CRC16_PLMAIN = 3'h1;
    localparam logic [2:0] STEP_CRC32_SWMAIN = 3'h2;
    localparam logic [2:0] STEP_CRC32_PLBOOT = 3'h3;
    localparam logic [2:0] STEP_KAT_ENC      = 3'h4;
    localparam logic [2:0] STEP_KAT_DEC      = 3'h5;
    localparam logic [2:0] STEP_KAT_HMAC     = 3'h6;
    localparam logic [2:0] STEP_LAST         = 3'h6;

    // Width select for the integrity engine
    localparam logic       CRC_WIDTH_16 = 1'b0;
    localparam logic       CRC_WIDTH_32 = 1'b1;

    // Sampling
    localparam logic [4:0] PORTION_COUNT   = 5'h11;
    localparam logic [4:0] PORTION_LAST    = 5'h10;
    localparam logic [4:0] PORTION_RESET   = 5'h00;
    localparam int         SAMPLE_BITS     = 2008000;
    localparam logic [20:0] SAMPLE_BITS_W  = 21'h1ea3c0;

    // Status patterns
    localparam logic [3:0] IO_STATUS_FAIL  = 4'hc;
    localparam logic [3:0] IO_STATUS_OK    = 4'h0;
    localparam logic [3:0] IO_STATUS_BUSY  = 4'h1;
    localparam logic [3:0] ADMIN_FAIL      = 4'hc;
    localparam logic [3:0] ADMIN_OK        = 4'h0;
    localparam logic [31:0] REASON_HMAC    = 32'h00001000;
    localparam logic [31:0] REASON_NONE    = 32'h00000000;

    typedef enum {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_READY,
        ST_FATAL
    } seq_state_t;

endpackage : selftest_pkg

// ==== verilog/selftest_sequencer.sv ====
`timescale 1ns/1ns
// Functional notes
// RULE_01 - Full self-test on every power-up or reset
// RULE_02 - Block crypto until all tests pass
// RULE_03 - Any failure enters sticky fatal error
// RULE_04 - Failure holds link down, status 11XXb
// RULE_05 - 16-bit CRC: switch boot, logic main
// RULE_06 - 32-bit CRC: switch main, logic boot
// RULE_07 - XTS-AES 256 encrypt and decrypt tests
// RULE_08 - Keyed-hash verify test covers SHA-256
// RULE_09 - Self-test starts without operator input
// RULE_10 - Switch-only reset while module keeps running
// RULE_11 - Switch firmware in 17 portions, one per reset
// RULE_12 - Each sample checks 2,008,000 bits
// RULE_13 - Sampling also runs all known answer tests
// RULE_14 - Deterministic portion order covers all
// RULE_15 - Firmware load: HMAC digest compare
// RULE_16 - Failed update answers admin status 11XXb
// RULE_17 - Authentication failure reason code 0x00001000
// RULE_18 - Update invocation starts authentication automatically
// RULE_19 - Data output inhibited during tests or error
// RULE_20 - Portion index survives switch reset, wraps
module selftest_sequencer
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // Switch-only reset request from the link error logic
    input  wire logic        SW_RESET_REQ,
    output logic             SW_RESET_OUT,
    // Integrity engine
    output logic             CRC_START,
    output logic             CRC_WIDTH,
    output logic [2:0]       CRC_IMAGE,
    output logic             CRC_SAMPLE,
    output logic [4:0]       CRC_PORTION,
    output logic [20:0]      CRC_BITS,
    input  wire logic        CRC_DONE,
    input  wire logic        CRC_PASS,
    // Known answer test engines
    output logic             KAT_START,
    output logic [2:0]       KAT_SEL,
    input  wire logic        KAT_DONE,
    input  wire logic        KAT_PASS,
    // Firmware update authentication
    input  wire logic        FW_UPDATE_REQ,
    output logic             HMAC_START,
    input  wire logic        HMAC_DONE,
    input  wire logic        HMAC_MATCH,
    output logic             FW_RESP_VALID,
    output logic [3:0]       ADMIN_STATUS,
    output logic [31:0]      ADMIN_REASON,
    // Status and gating
    output logic             CRYPTO_ENABLE,
    output logic             LINK_ENABLE,
    output logic             DATA_OUT_ENABLE,
    output logic [3:0]       IO_STATUS,
    output logic             FATAL_ERROR,
    output logic             SAMPLE_BUSY
);

    selftest_pkg::seq_state_t state_q;
    selftest_pkg::seq_state_t state_d;

    logic [2:0]  step_q;
    logic        sample_q;
    logic [4:0]  portion_q;
    logic        powerup_ok_q;
    logic        hmac_busy_q;
    logic        resp_q;
    logic [3:0]  admin_q;
    logic [31:0] reason_q;
    logic        swrst_q;
    logic        req_s1_q;
    logic        req_s2_q;
    logic        upd_s1_q;
    logic        upd_s2_q;
    logic        upd_prev_q;

    function automatic logic is_crc_step(input logic [2:0] s);
        is_crc_step = (s <= selftest_pkg::STEP_CRC32_PLBOOT);
    endfunction : is_crc_step

    // Async pins pass two flops first
    always_ff @(posedge CLK)
    begin
        req_s1_q <= SW_RESET_REQ;
        req_s2_q <= req_s1_q;
        upd_s1_q <= FW_UPDATE_REQ;
        upd_s2_q <= upd_s1_q;
    end

    wire step_done  = is_crc_step(step_q) ? CRC_DONE : KAT_DONE;
    wire step_pass  = is_crc_step(step_q) ? CRC_PASS : KAT_PASS;
    wire last_step  = (step_q == selftest_pkg::STEP_LAST);
    wire sw_req     = req_s2_q && (state_q == selftest_pkg::ST_READY);
    wire upd_rise   = upd_s2_q && !upd_prev_q;
    // Sampling covers only the switch main image
    wire [2:0] first_step = sample_q ? selftest_pkg::STEP_CRC32_SWMAIN
                                     : selftest_pkg::STEP_CRC16_SWBOOT;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            selftest_pkg::ST_IDLE:  state_d = selftest_pkg::ST_ISSUE;  // see RULE_09
            selftest_pkg::ST_ISSUE: state_d = selftest_pkg::ST_WAIT;
            selftest_pkg::ST_WAIT:
                if (step_done && !step_pass)
                    state_d = selftest_pkg::ST_FATAL;                  // see RULE_03
                else if (step_done && last_step)
                    state_d = selftest_pkg::ST_READY;
                else if (step_done)
                    state_d = selftest_pkg::ST_ISSUE;
            selftest_pkg::ST_READY:
                if (sw_req)
                    state_d = selftest_pkg::ST_ISSUE;                  // see RULE_10
            selftest_pkg::ST_FATAL: state_d = selftest_pkg::ST_FATAL;  // see RULE_03
            default:                state_d = selftest_pkg::ST_FATAL;
        endcase
    end

    // Reset restarts the whole sequence from the first image
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state_q      <= selftest_pkg::ST_IDLE;                     // see RULE_01
            step_q       <= selftest_pkg::STEP_CRC16_SWBOOT;
            sample_q     <= 1'b0;
            powerup_ok_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (sw_req)
            begin
                sample_q <= 1'b1;
                step_q   <= selftest_pkg::STEP_CRC32_SWMAIN;           // see RULE_11
            end
            else if (state_q == selftest_pkg::ST_IDLE)
                step_q <= first_step;
            else if (state_q == selftest_pkg::ST_WAIT && step_done && step_pass && !last_step)
            begin
                // Sampling skips the other images, then runs every test
                if (sample_q && step_q == selftest_pkg::STEP_CRC32_SWMAIN)
                    step_q <= selftest_pkg::STEP_KAT_ENC;              // see RULE_13
                else
                    step_q <= step_q + 3'h1;
            end
            if (state_d == selftest_pkg::ST_READY && state_q == selftest_pkg::ST_WAIT)
            begin
                powerup_ok_q <= 1'b1;
                sample_q     <= 1'b0;
            end
        end
    end

    // Portion index is not cleared by the switch reset; only module reset or the wrap after PORTION_LAST clears it
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            portion_q <= selftest_pkg::PORTION_RESET;
        else if (sample_q && state_q == selftest_pkg::ST_WAIT && step_done && step_pass
                 && step_q == selftest_pkg::STEP_CRC32_SWMAIN)
            portion_q <= (portion_q == selftest_pkg::PORTION_LAST)
                       ? selftest_pkg::PORTION_RESET : portion_q + 5'h01;  // see RULE_20
    end

    // Switch reset pulse; the rest of the module keeps running
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            swrst_q <= 1'b0;
        else
            swrst_q <= sw_req;                                         // see RULE_10
    end

    // Firmware update authentication
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            upd_prev_q  <= 1'b0;
            hmac_busy_q <= 1'b0;
            resp_q      <= 1'b0;
            admin_q     <= selftest_pkg::ADMIN_OK;
            reason_q    <= selftest_pkg::REASON_NONE;
        end
        else
        begin
            upd_prev_q <= upd_s2_q;
            resp_q     <= 1'b0;
            if (upd_rise && !hmac_busy_q && CRYPTO_ENABLE)
                hmac_busy_q <= 1'b1;                                   // see RULE_18
            else if (hmac_busy_q && HMAC_DONE)
            begin
                hmac_busy_q <= 1'b0;
                resp_q      <= 1'b1;
                admin_q     <= HMAC_MATCH ? selftest_pkg::ADMIN_OK
                                          : selftest_pkg::ADMIN_FAIL;      // see RULE_16
                reason_q    <= HMAC_MATCH ? selftest_pkg::REASON_NONE
                                          : selftest_pkg::REASON_HMAC;     // see RULE_17
            end
        end
    end

    wire issuing = (state_q == selftest_pkg::ST_ISSUE);

    // Engine commands
    assign CRC_START   = issuing && is_crc_step(step_q);
    assign CRC_WIDTH   = (step_q <= selftest_pkg::STEP_CRC16_PLMAIN)
                       ? selftest_pkg::CRC_WIDTH_16 : selftest_pkg::CRC_WIDTH_32;  // see RULE_05
    assign CRC_IMAGE   = step_q;                                       // see RULE_06
    assign CRC_SAMPLE  = sample_q;
    assign CRC_PORTION = portion_q;                                    // see RULE_14
    assign CRC_BITS    = sample_q ? selftest_pkg::SAMPLE_BITS_W : 21'h000000;  // see RULE_12
    assign KAT_START   = issuing && !is_crc_step(step_q);              // see RULE_07
    assign KAT_SEL     = step_q;                                       // see RULE_08
    assign HMAC_START  = upd_rise && !hmac_busy_q && CRYPTO_ENABLE;    // see RULE_15
    assign FW_RESP_VALID = resp_q;
    assign ADMIN_STATUS  = admin_q;
    assign ADMIN_REASON  = reason_q;
    assign SW_RESET_OUT  = swrst_q;

    // Gating
    assign FATAL_ERROR     = (state_q == selftest_pkg::ST_FATAL);
    assign CRYPTO_ENABLE   = (state_q == selftest_pkg::ST_READY);      // see RULE_02
    assign DATA_OUT_ENABLE = CRYPTO_ENABLE;                            // see RULE_19
    // Link trains only after the first power-up pass; a sampling run leaves it up
    assign LINK_ENABLE     = powerup_ok_q && !FATAL_ERROR;             // see RULE_04
    assign IO_STATUS       = FATAL_ERROR ? selftest_pkg::IO_STATUS_FAIL
                           : (CRYPTO_ENABLE ? selftest_pkg::IO_STATUS_OK
                                            : selftest_pkg::IO_STATUS_BUSY);  // see RULE_04
    assign SAMPLE_BUSY     = sample_q;

    // Assertions
    // Switch reset and the switch image check start together, then both go quiet
    sequence sw_kick_s;
        SW_RESET_OUT && sample_q && CRC_START
            && CRC_IMAGE == selftest_pkg::STEP_CRC32_SWMAIN;
    endsequence
    sequence sw_quiet_s;
        !SW_RESET_OUT && !CRC_START && sample_q;
    endsequence
    sequence auth_fail_s;
        FW_RESP_VALID && ADMIN_STATUS[3:2] == 2'b11
            && ADMIN_REASON == selftest_pkg::REASON_HMAC;
    endsequence

    fatal_sticky_a: assert property (@(posedge CLK) disable iff (!RESET_N)  // see RULE_03
        FATAL_ERROR |=> FATAL_ERROR)
        else $error("fatal state left");
    fail_enters_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_03
        (state_q == selftest_pkg::ST_WAIT && step_done && !step_pass) |=> FATAL_ERROR)
        else $error("failure not fatal");
    fatal_status_a: assert property (@(posedge CLK) disable iff (!RESET_N)  // see RULE_04
        FATAL_ERROR |-> (IO_STATUS[3:2] == 2'b11 && !LINK_ENABLE))
        else $error("fatal status wrong");
    crypto_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_02
        CRYPTO_ENABLE |-> (powerup_ok_q && !sample_q))
        else $error("crypto enabled early");
    ready_entry_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_02
        (state_q == selftest_pkg::ST_WAIT && step_done && step_pass && last_step)
        |=> (CRYPTO_ENABLE && LINK_ENABLE))
        else $error("ready not entered");
    data_inhibit_a: assert property (@(posedge CLK) disable iff (!RESET_N)  // see RULE_19
        (sample_q || FATAL_ERROR) |-> !DATA_OUT_ENABLE)
        else $error("data out not inhibited");
    auto_start_a: assert property (@(posedge CLK)                           // see RULE_09
        $rose(RESET_N) |-> ##1 CRC_START)
        else $error("no auto start");
    crc16_width_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_05
        (CRC_START && step_q <= selftest_pkg::STEP_CRC16_PLMAIN)
        |-> CRC_WIDTH == selftest_pkg::CRC_WIDTH_16)
        else $error("crc width wrong");
    crc32_width_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_06
        (CRC_START && step_q >= selftest_pkg::STEP_CRC32_SWMAIN)
        |-> CRC_WIDTH == selftest_pkg::CRC_WIDTH_32)
        else $error("crc32 width wrong");
    portion_wrap_a: assert property (@(posedge CLK) disable iff (!RESET_N)  // see RULE_20
        (portion_q == selftest_pkg::PORTION_LAST && $changed(portion_q)) or
        !$changed(portion_q) or portion_q != selftest_pkg::PORTION_RESET or
        $past(portion_q) == selftest_pkg::PORTION_LAST)
        else $error("portion wrap wrong");
    portion_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)  // see RULE_14
        ($changed(portion_q) && portion_q != selftest_pkg::PORTION_RESET)
        |-> portion_q == $past(portion_q) + 5'h01)
        else $error("portion skipped");
    sw_reset_a: assert property (@(posedge CLK) disable iff (!RESET_N)      // see RULE_11
        sw_req |=> sw_kick_s ##1 sw_quiet_s)
        else $error("switch reset sequence wrong");
    sample_bits_a: assert property (@(posedge CLK) disable iff (!RESET_N)   // see RULE_12
        (CRC_START && sample_q) |-> CRC_BITS == selftest_pkg::SAMPLE_BITS_W)
        else $error("sample size wrong");
    sample_kat_a: assert property (@(posedge CLK) disable iff (!RESET_N)    // see RULE_13
        (sample_q && state_q == selftest_pkg::ST_WAIT && step_done && step_pass
            && step_q == selftest_pkg::STEP_CRC32_SWMAIN)
        |=> (KAT_START && KAT_SEL == selftest_pkg::STEP_KAT_ENC))
        else $error("sampling skipped tests");
    auth_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)    // see RULE_18
        HMAC_START |=> hmac_busy_q)
        else $error("authentication not started");
    auth_fail_a: assert property (@(posedge CLK) disable iff (!RESET_N)     // see RULE_17
        (hmac_busy_q && HMAC_DONE && !HMAC_MATCH) |=> auth_fail_s)
        else $error("auth fail response wrong");

endmodule : selftest_sequencer

// ==== verif/engine_model.sv ====
`timescale 1ns/1ns
module engine_model
(
    // Clock
    input  wire logic       CLK,
    // Request and answer shaping
    input  wire logic       START,
    input  wire logic       OK,
    input  wire logic [3:0] DELAY,
    // Result
    output logic            DONE,
    output logic            PASS
);
    // Start is combinational, so it is looked at on the falling edge
    initial
    begin
        DONE = 1'b0;
        PASS = 1'b0;
        forever
        begin
            @(negedge CLK);
            if (START === 1'b1)
            begin
                repeat (DELAY + 1) @(posedge CLK);
                #1;
                DONE = 1'b1;
                PASS = OK;
                @(posedge CLK);
                #1;
                DONE = 1'b0;
                // Result line does not keep its last value once done drops
                PASS = ~OK;
            end
        end
    end
endmodule : engine_model

// ==== verif/test_selftest_sequencer.sv ====
`timescale 1ns/1ns
module test_selftest_sequencer;
    logic        CLK, RESET_N, SW_RESET_REQ, FW_UPDATE_REQ, crc_ok, kat_ok, hmac_ok;
    logic [3:0]  delay, kat_d, io_status, admin_status;
    logic        sw_reset_out, crc_start, crc_width, crc_sample, crc_done, crc_pass;
    logic        kat_start, kat_done, kat_pass, hmac_start, hmac_done, hmac_match;
    logic        fw_resp_valid, crypto_enable, link_enable, data_out_enable;
    logic        fatal_error, sample_busy;
    logic [2:0]  crc_image, kat_sel;
    logic [4:0]  crc_portion;
    logic [20:0] crc_bits;
    logic [31:0] admin_reason, rng, seen_q[$], exp_q[$];
    int          n_mismatch, total_checks, portion_m, n_swrst, n0, n_resp, n1;

    selftest_sequencer uut (.CLK(CLK), .RESET_N(RESET_N), .SW_RESET_REQ(SW_RESET_REQ),
        .SW_RESET_OUT(sw_reset_out), .CRC_START(crc_start), .CRC_WIDTH(crc_width),
        .CRC_IMAGE(crc_image), .CRC_SAMPLE(crc_sample), .CRC_PORTION(crc_portion),
        .CRC_BITS(crc_bits), .CRC_DONE(crc_done), .CRC_PASS(crc_pass),
        .KAT_START(kat_start), .KAT_SEL(kat_sel), .KAT_DONE(kat_done), .KAT_PASS(kat_pass),
        .FW_UPDATE_REQ(FW_UPDATE_REQ), .HMAC_START(hmac_start), .HMAC_DONE(hmac_done),
        .HMAC_MATCH(hmac_match), .FW_RESP_VALID(fw_resp_valid), .ADMIN_STATUS(admin_status),
        .ADMIN_REASON(admin_reason), .CRYPTO_ENABLE(crypto_enable), .LINK_ENABLE(link_enable),
        .DATA_OUT_ENABLE(data_out_enable), .IO_STATUS(io_status), .FATAL_ERROR(fatal_error),
        .SAMPLE_BUSY(sample_busy));
    engine_model crc_eng (.CLK(CLK), .START(crc_start), .OK(crc_ok), .DELAY(delay),
        .DONE(crc_done), .PASS(crc_pass));
    engine_model kat_eng (.CLK(CLK), .START(kat_start), .OK(kat_ok), .DELAY(kat_d),
        .DONE(kat_done), .PASS(kat_pass));
    engine_model hmac_eng (.CLK(CLK), .START(hmac_start), .OK(hmac_ok), .DELAY(delay),
        .DONE(hmac_done), .PASS(hmac_match));
    assign kat_d = ~delay;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic wait_hi(input int which);
        int   k;
        logic s;
        k = 0;
        s = 1'b0;
        while (s !== 1'b1 && k < 3000)
        begin
            @(posedge CLK);
            #1;
            s = (which == 0) ? crypto_enable : (which == 1) ? sw_reset_out :
                (which == 2) ? fw_resp_valid : fatal_error;
            k++;
        end
        check(s, 1'b1, "wait timed out");
    endtask : wait_hi

    task automatic do_reset;
        RESET_N = 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        check(io_status, selftest_pkg::IO_STATUS_BUSY, "status in reset");
        check(link_enable | crypto_enable | data_out_enable, 1'b0, "enable in reset");
        RESET_N = 1'b1;
        seen_q = {};
        portion_m = 0;
    endtask : do_reset

    task automatic expect_run(input logic sampling);
        exp_q = {};
        if (sampling)
            exp_q.push_back({3'b111, 5'(portion_m), selftest_pkg::SAMPLE_BITS_W, 3'h2});
        else
            for (int i = 0; i < 4; i++)
                exp_q.push_back({1'b1, 1'(i > 1), 1'b0, 26'h0, 3'(i)});
        for (int i = 4; i < 7; i++)
            exp_q.push_back({29'h0, 3'(i)});
        wait_hi(0);
        check(seen_q.size(), exp_q.size(), "step count");
        foreach (exp_q[i])
            check(seen_q[i], exp_q[i], "step code");
        seen_q = {};
    endtask : expect_run

    task automatic sw_reset;
        rng = xs(rng);
        delay = rng[3:0];
        n0 = n_swrst;
        SW_RESET_REQ = 1'b1;
        wait_hi(1);
        check(sample_busy, 1'b1, "sample busy");
        SW_RESET_REQ = 1'b0;
        expect_run(1'b1);
        check(n_swrst, n0 + 1, "switch reset pulses");
        portion_m = (portion_m + 1) % 17;
    endtask : sw_reset

    always @(negedge CLK)
    begin
        if (crc_start === 1'b1)
            seen_q.push_back({1'b1, crc_width, crc_sample, crc_sample ? crc_portion : 5'h00,
                crc_bits, crc_image});
        if (kat_start === 1'b1)
            seen_q.push_back({29'h0, kat_sel});
        if ((crc_start | kat_start) === 1'b1)
            check(crypto_enable | data_out_enable, 1'b0, "enable while testing");
        if (sample_busy === 1'b1)
            check(link_enable, 1'b1, "link dropped in sampling");
        if (sw_reset_out === 1'b1)
            n_swrst++;
        if (fw_resp_valid === 1'b1)
            n_resp++;
    end

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // Longest path is 18 sampling runs of at most about 60 cycles each
    initial
    begin
        repeat (40000) @(posedge CLK);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        {RESET_N, SW_RESET_REQ, FW_UPDATE_REQ} = 3'b000;
        {crc_ok, kat_ok, hmac_ok} = 3'b111;
        rng = 32'hca07;
        delay = 4'h3;
        do_reset();
        expect_run(1'b0);
        check(io_status, selftest_pkg::IO_STATUS_OK, "status ready");
        check(link_enable, 1'b1, "link up");
        $display("test power-up done");
        for (int r = 0; r < 18; r++)
            sw_reset();
        $display("test sampling done");
        for (int i = 0; i < 6; i++)
        begin
            rng = xs(rng);
            // First two runs force a fail and a pass so both answers are seen
            hmac_ok = (i < 2) ? 1'(i) : rng[0];
            delay = rng[7:4];
            FW_UPDATE_REQ = 1'b1;
            wait_hi(2);
            check(admin_status & (hmac_ok ? 4'hf : 4'hc),
                hmac_ok ? selftest_pkg::ADMIN_OK : selftest_pkg::ADMIN_FAIL, "admin");
            check(admin_reason, hmac_ok ? 32'h0 : 32'h00001000, "reason");
            FW_UPDATE_REQ = 1'b0;
            repeat (4) @(posedge CLK);
            #1;
        end
        $display("test update done");
        for (int f = 0; f < 2; f++)
        begin
            crc_ok = 1'(f);
            kat_ok = 1'(1 - f);
            do_reset();
            wait_hi(3);
            SW_RESET_REQ = 1'b1;
            FW_UPDATE_REQ = 1'b1;
            n0 = n_swrst;
            n1 = n_resp;
            repeat (40) @(posedge CLK);
            #1;
            check(fatal_error, 1'b1, "fatal sticky");
            check(io_status[3:2], 2'b11, "fatal status");
            check(link_enable | crypto_enable | data_out_enable, 1'b0, "fatal gating");
            check(n_swrst, n0, "switch reset in fatal");
            check(n_resp, n1, "update answered in fatal");
            {SW_RESET_REQ, FW_UPDATE_REQ} = 2'b00;
            {crc_ok, kat_ok} = 2'b11;
        end
        do_reset();
        expect_run(1'b0);
        sw_reset();
        $display("test fatal done");
        finish_test();
    end
endmodule : test_selftest_sequencer
